// >>> include/vrpc_regs.vh
// Register map, field positions and constants of the voice control block
`ifndef VRPC_REGS_VH
`define VRPC_REGS_VH

// ==================================================
// Register indices
`define VRPC_ADDR_W 4
`define VRPC_IDX_GAIN 4'h0
`define VRPC_IDX_RATE 4'h1
`define VRPC_IDX_COMP 4'h2
`define VRPC_IDX_SPKR 4'h3
`define VRPC_IDX_RECL 4'h4
`define VRPC_IDX_RECH 4'h5
`define VRPC_IDX_PLAL 4'h6
`define VRPC_IDX_PLAH 4'h7
`define VRPC_IDX_REQE 4'h8
`define VRPC_IDX_STAT 4'h9

// ==================================================
// Reset values
`define VRPC_RST_BYTE 8'h00

// ==================================================
// Field positions
`define VRPC_GAIN_MICUN 7
`define VRPC_GAIN_RUN 6
`define VRPC_RATE_REC_HI 7
`define VRPC_RATE_REC_LO 6
`define VRPC_RATE_PLA_HI 5
`define VRPC_RATE_PLA_LO 4
`define VRPC_RATE_AIN 2
`define VRPC_RATE_AMP 1
`define VRPC_RATE_DAC 0
`define VRPC_COMP_RLAW 3
`define VRPC_COMP_PLAW 2
`define VRPC_COMP_RCMP 1
`define VRPC_COMP_PEXP 0
`define VRPC_SPKR_UNMUTE 7
`define VRPC_REQE_REC 0
`define VRPC_REQE_PLA 1

// ==================================================
// Sample rates in Hz, selected by a 2-bit field
`define VRPC_RATE_CODE_8K 2'b00
`define VRPC_RATE_CODE_16K 2'b01
`define VRPC_RATE_CODE_12K 2'b10
`define VRPC_HZ_8K 32'd8000
`define VRPC_HZ_16K 32'd16000
`define VRPC_HZ_12K 32'd12000
`define VRPC_HZ_24K 32'd24000
`define VRPC_CLK_HZ 25000000

// ==================================================
// Gain and companding constants
`define VRPC_GAIN_MAX 6'h27
`define VRPC_GAIN_FRAC 12
`define VRPC_MU_BIAS 16'h0084
`define VRPC_MU_CLIP 16'h7f7b
`define VRPC_A_XOR 8'h55
`define VRPC_A_SEG1 12'h108
`define VRPC_A_HALF 12'h008

`endif

// >>> core/vrpc_voice_ctrl.v
// Voice record and play control: PLL gating, sample timing, gain, companding
`timescale 1ns/1ps
`include "vrpc_regs.vh"

module vrpc_voice_ctrl #(
    parameter CLK_HZ = `VRPC_CLK_HZ,
    parameter ACC_W = 32
) (
    input wire clk_sys,
    input wire rst_n,
    input wire [`VRPC_ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire power_down,
    input wire pll_lock,
    input wire [15:0] adc_data,
    output reg pll_enable,
    output reg input_converter_enable,
    output reg input_converter_run,
    output reg output_converter_enable,
    output reg amplifier_enable,
    output reg microphone_unmute,
    output reg speaker_unmute,
    output reg [6:0] speaker_volume,
    output reg record_request,
    output reg play_request,
    output reg [15:0] dac_data,
    output reg dac_strobe
);

    // ==================================================
    // Companding and gain functions
    function [16:0] vrpc_gain_q12;
        input [5:0] code;
        begin
            case (code)
                6'h00: vrpc_gain_q12 = 17'd4096;
                6'h01: vrpc_gain_q12 = 17'd4339;
                6'h02: vrpc_gain_q12 = 17'd4596;
                6'h03: vrpc_gain_q12 = 17'd4868;
                6'h04: vrpc_gain_q12 = 17'd5157;
                6'h05: vrpc_gain_q12 = 17'd5462;
                6'h06: vrpc_gain_q12 = 17'd5786;
                6'h07: vrpc_gain_q12 = 17'd6129;
                6'h08: vrpc_gain_q12 = 17'd6492;
                6'h09: vrpc_gain_q12 = 17'd6877;
                6'h0a: vrpc_gain_q12 = 17'd7284;
                6'h0b: vrpc_gain_q12 = 17'd7716;
                6'h0c: vrpc_gain_q12 = 17'd8173;
                6'h0d: vrpc_gain_q12 = 17'd8657;
                6'h0e: vrpc_gain_q12 = 17'd9170;
                6'h0f: vrpc_gain_q12 = 17'd9714;
                6'h10: vrpc_gain_q12 = 17'd10289;
                6'h11: vrpc_gain_q12 = 17'd10899;
                6'h12: vrpc_gain_q12 = 17'd11545;
                6'h13: vrpc_gain_q12 = 17'd12229;
                6'h14: vrpc_gain_q12 = 17'd12953;
                6'h15: vrpc_gain_q12 = 17'd13720;
                6'h16: vrpc_gain_q12 = 17'd14533;
                6'h17: vrpc_gain_q12 = 17'd15394;
                6'h18: vrpc_gain_q12 = 17'd16306;
                6'h19: vrpc_gain_q12 = 17'd17272;
                6'h1a: vrpc_gain_q12 = 17'd18295;
                6'h1b: vrpc_gain_q12 = 17'd19379;
                6'h1c: vrpc_gain_q12 = 17'd20528;
                6'h1d: vrpc_gain_q12 = 17'd21744;
                6'h1e: vrpc_gain_q12 = 17'd23033;
                6'h1f: vrpc_gain_q12 = 17'd24398;
                6'h20: vrpc_gain_q12 = 17'd25843;
                6'h21: vrpc_gain_q12 = 17'd27374;
                6'h22: vrpc_gain_q12 = 17'd28996;
                6'h23: vrpc_gain_q12 = 17'd30714;
                6'h24: vrpc_gain_q12 = 17'd32534;
                6'h25: vrpc_gain_q12 = 17'd34461;
                6'h26: vrpc_gain_q12 = 17'd36503;
                default: vrpc_gain_q12 = 17'd38669;
            endcase
        end
    endfunction

    function [15:0] vrpc_abs;
        input [15:0] x;
        begin
            vrpc_abs = x[15] ? (~x + 16'h0001) : x;
        end
    endfunction

    function [7:0] vrpc_mu_enc;
        input [15:0] x;
        reg [15:0] mag;
        reg [15:0] tmp;
        reg [2:0] seg;
        integer i;
        begin
            mag = vrpc_abs(x);
            if (mag > `VRPC_MU_CLIP) begin
                mag = `VRPC_MU_CLIP;
            end
            mag = mag + `VRPC_MU_BIAS;
            seg = 3'd0;
            for (i = 0; i < 8; i = i + 1) begin
                if (mag[i+7]) begin
                    seg = i[2:0];
                end
            end
            tmp = mag >> ({1'b0, seg} + 4'd3);
            vrpc_mu_enc = ~{x[15], seg, tmp[3:0]};
        end
    endfunction

    function [15:0] vrpc_mu_dec;
        input [7:0] code;
        reg [7:0] c;
        reg [15:0] t;
        begin
            c = ~code;
            t = ({9'h000, c[3:0], 3'b000} + `VRPC_MU_BIAS) << c[6:4];
            t = t - `VRPC_MU_BIAS;
            vrpc_mu_dec = c[7] ? (~t + 16'h0001) : t;
        end
    endfunction

    function [7:0] vrpc_a_enc;
        input [15:0] x;
        reg [15:0] mag;
        reg [11:0] v;
        reg [11:0] tmp;
        reg [2:0] seg;
        integer i;
        begin
            mag = vrpc_abs(x) >> 3;
            v = (mag > 16'h0fff) ? 12'hfff : mag[11:0];
            seg = 3'd0;
            for (i = 1; i < 8; i = i + 1) begin
                if (v[i+4]) begin
                    seg = i[2:0];
                end
            end
            tmp = (seg == 3'd0) ? (v >> 1) : (v >> seg);
            vrpc_a_enc = {~x[15], seg, tmp[3:0]} ^ `VRPC_A_XOR;
        end
    endfunction

    function [15:0] vrpc_a_dec;
        input [7:0] code;
        reg [7:0] c;
        reg [11:0] base;
        reg [15:0] t;
        begin
            c = code ^ `VRPC_A_XOR;
            if (c[6:4] == 3'd0) begin
                base = {4'h0, c[3:0], 4'h0} + `VRPC_A_HALF;
                t = {4'h0, base};
            end else begin
                base = {4'h0, c[3:0], 4'h0} + `VRPC_A_SEG1;
                t = {4'h0, base} << (c[6:4] - 3'd1);
            end
            vrpc_a_dec = c[7] ? t : (~t + 16'h0001);
        end
    endfunction

    function [ACC_W-1:0] vrpc_rate_hz;
        input [1:0] sel;
        begin
            case (sel)
                `VRPC_RATE_CODE_8K: vrpc_rate_hz = `VRPC_HZ_8K;
                `VRPC_RATE_CODE_16K: vrpc_rate_hz = `VRPC_HZ_16K;
                `VRPC_RATE_CODE_12K: vrpc_rate_hz = `VRPC_HZ_12K;
                default: vrpc_rate_hz = `VRPC_HZ_24K;
            endcase
        end
    endfunction

    // ==================================================
    // Control registers
    reg [7:0] mic_gain_control;
    reg [7:0] rate_and_enable_control;
    reg [3:0] compander_control;
    reg [7:0] speaker_volume_control;
    reg [7:0] record_data_low;
    reg [7:0] record_data_high;
    reg [7:0] play_data_low;
    reg [7:0] play_data_high;
    reg [1:0] request_enable_control;

    wire wr_gain = reg_wr && (reg_addr == `VRPC_IDX_GAIN);
    wire wr_rate = reg_wr && (reg_addr == `VRPC_IDX_RATE);
    wire wr_comp = reg_wr && (reg_addr == `VRPC_IDX_COMP);
    wire wr_spkr = reg_wr && (reg_addr == `VRPC_IDX_SPKR);
    wire wr_plal = reg_wr && (reg_addr == `VRPC_IDX_PLAL);
    wire wr_plah = reg_wr && (reg_addr == `VRPC_IDX_PLAH);
    wire wr_reqe = reg_wr && (reg_addr == `VRPC_IDX_REQE);

    wire ain_en_bit = rate_and_enable_control[`VRPC_RATE_AIN];
    wire amp_en_bit = rate_and_enable_control[`VRPC_RATE_AMP];
    wire dac_en_bit = rate_and_enable_control[`VRPC_RATE_DAC];
    wire run_bit = mic_gain_control[`VRPC_GAIN_RUN];
    wire micun_bit = mic_gain_control[`VRPC_GAIN_MICUN];
    wire spkun_bit = speaker_volume_control[`VRPC_SPKR_UNMUTE];
    wire rec_req_en = request_enable_control[`VRPC_REQE_REC];
    wire pla_req_en = request_enable_control[`VRPC_REQE_PLA];
    wire [1:0] rec_rate = rate_and_enable_control[
        `VRPC_RATE_REC_HI:`VRPC_RATE_REC_LO];
    wire [1:0] pla_rate = rate_and_enable_control[
        `VRPC_RATE_PLA_HI:`VRPC_RATE_PLA_LO];

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mic_gain_control <= `VRPC_RST_BYTE;
            rate_and_enable_control <= `VRPC_RST_BYTE;
            compander_control <= 4'h0;
            speaker_volume_control <= `VRPC_RST_BYTE;
            play_data_low <= `VRPC_RST_BYTE;
            play_data_high <= `VRPC_RST_BYTE;
            request_enable_control <= 2'b00;
        end else begin
            if (wr_gain) begin
                mic_gain_control <= reg_wdata;
            end
            // enable bits at 2, 1, 0; bit 3 unused
            if (wr_rate) begin
                rate_and_enable_control <= {reg_wdata[7:4], 1'b0,
                    reg_wdata[2:0]};
            end
            if (wr_comp) begin
                compander_control <= reg_wdata[3:0];
            end
            if (wr_spkr) begin
                speaker_volume_control <= reg_wdata;
            end
            if (wr_plal) begin
                play_data_low <= reg_wdata;
            end
            if (wr_plah) begin
                play_data_high <= reg_wdata;
            end
            if (wr_reqe) begin
                request_enable_control <= reg_wdata[1:0];
            end
        end
    end

    // ==================================================
    // PLL lock synchroniser and gating
    reg lock_s1;
    reg lock_s2;
    reg lock_s3;
    reg pll_stable;

    // PLL runs outside power-down while any enabling bit except the amplifier enable is set
    wire next_pll_enable = !power_down && (ain_en_bit || run_bit ||
        dac_en_bit || rec_req_en || pla_req_en);

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lock_s1 <= 1'b0;
            lock_s2 <= 1'b0;
            lock_s3 <= 1'b0;
            pll_stable <= 1'b0;
            pll_enable <= 1'b0;
        end else begin
            lock_s1 <= pll_lock;
            lock_s2 <= lock_s1;
            lock_s3 <= lock_s2;
            pll_enable <= next_pll_enable;
            // stable only while enabled and lock confirmed
            if (!pll_enable || !next_pll_enable) begin
                pll_stable <= 1'b0;
            end else if (lock_s2 == lock_s3) begin
                pll_stable <= lock_s3;
            end
        end
    end

    // ==================================================
    // Sample rate dividers
    reg [ACC_W-1:0] rec_acc;
    reg [ACC_W-1:0] pla_acc;
    wire [ACC_W-1:0] clk_hz = CLK_HZ[ACC_W-1:0];
    // fractional divide of the clock by the selected rate
    // rate field picks 8, 16, 12 or 24 kHz
    wire [ACC_W-1:0] rec_sum = rec_acc + vrpc_rate_hz(rec_rate);
    wire [ACC_W-1:0] pla_sum = pla_acc + vrpc_rate_hz(pla_rate);
    wire rec_tick = pll_stable && (rec_sum >= clk_hz);
    wire pla_tick = pll_stable && (pla_sum >= clk_hz);

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rec_acc <= {ACC_W{1'b0}};
            pla_acc <= {ACC_W{1'b0}};
        end else if (!pll_stable) begin
            rec_acc <= {ACC_W{1'b0}};
            pla_acc <= {ACC_W{1'b0}};
        end else begin
            rec_acc <= rec_tick ? (rec_sum - clk_hz) : rec_sum;
            pla_acc <= pla_tick ? (pla_sum - clk_hz) : pla_sum;
        end
    end

    // ==================================================
    // Record path
    // muted microphone contributes zero
    wire [15:0] mic_in = micun_bit ? adc_data : 16'h0000;
    // digital gain on the 16-bit sample
    // gain code looked up in half-dB steps
    wire signed [33:0] gain_prod = $signed(mic_in) *
        $signed({1'b0, vrpc_gain_q12(mic_gain_control[5:0])});
    wire signed [21:0] gain_shift = gain_prod[33:`VRPC_GAIN_FRAC];
    wire gain_pos_ovf = !gain_shift[21] && (gain_shift[20:15] != 6'h00);
    wire gain_neg_ovf = gain_shift[21] && (gain_shift[20:15] != 6'h3f);
    wire [15:0] gained = gain_pos_ovf ? 16'h7fff :
        (gain_neg_ovf ? 16'h8000 : gain_shift[15:0]);
    // law select 0 mu-law, 1 A-law
    wire [7:0] rec_code = compander_control[`VRPC_COMP_RLAW] ?
        vrpc_a_enc(gained) : vrpc_mu_enc(gained);
    // converter only produces data while run and enabled
    wire ain_active = ain_en_bit && run_bit && !power_down;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            record_data_low <= `VRPC_RST_BYTE;
            record_data_high <= `VRPC_RST_BYTE;
        end else if (rec_tick && ain_active) begin
            if (compander_control[`VRPC_COMP_RCMP]) begin
                // compressed code in high byte only
                record_data_high <= rec_code;
            end else begin
                record_data_high <= gained[15:8];
                record_data_low <= gained[7:0];
            end
        end
    end

    // ==================================================
    // Play path
    wire [15:0] pla_dec = compander_control[`VRPC_COMP_PLAW] ?
        vrpc_a_dec(play_data_high) : vrpc_mu_dec(play_data_high);
    // speaker mute disables converter and amplifier
    wire next_dac_en = dac_en_bit && spkun_bit && !power_down;
    wire next_amp_en = amp_en_bit && spkun_bit && !power_down;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dac_data <= 16'h0000;
            dac_strobe <= 1'b0;
        end else begin
            dac_strobe <= pla_tick && next_dac_en;
            if (pla_tick && next_dac_en) begin
                dac_data <= compander_control[`VRPC_COMP_PEXP] ? pla_dec :
                    {play_data_high, play_data_low};
            end else if (!next_dac_en) begin
                dac_data <= 16'h0000;
            end
        end
    end

    // ==================================================
    // Requests and converter controls
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            record_request <= 1'b0;
            play_request <= 1'b0;
            input_converter_enable <= 1'b0;
            input_converter_run <= 1'b0;
            output_converter_enable <= 1'b0;
            amplifier_enable <= 1'b0;
            microphone_unmute <= 1'b0;
            speaker_unmute <= 1'b0;
            speaker_volume <= 7'h00;
        end else begin
            // requests need only their own enable
            // one record request per record sample
            record_request <= rec_tick && rec_req_en;
            // one play request per play sample
            play_request <= pla_tick && pla_req_en;
            input_converter_enable <= ain_en_bit && !power_down;
            // converter held in reset while run bit clear
            input_converter_run <= ain_en_bit && run_bit && !power_down;
            output_converter_enable <= next_dac_en;
            amplifier_enable <= next_amp_en;
            microphone_unmute <= micun_bit;
            speaker_unmute <= spkun_bit;
            speaker_volume <= speaker_volume_control[6:0];
        end
    end

    // ==================================================
    // Register read port
    reg [7:0] next_rdata;

    always @* begin
        next_rdata = 8'h00;
        case (reg_addr)
            `VRPC_IDX_GAIN: next_rdata = mic_gain_control;
            `VRPC_IDX_RATE: next_rdata = rate_and_enable_control;
            `VRPC_IDX_COMP: next_rdata = {4'h0, compander_control};
            `VRPC_IDX_SPKR: next_rdata = speaker_volume_control;
            `VRPC_IDX_RECL: next_rdata = record_data_low;
            `VRPC_IDX_RECH: next_rdata = record_data_high;
            `VRPC_IDX_PLAL: next_rdata = play_data_low;
            `VRPC_IDX_PLAH: next_rdata = play_data_high;
            `VRPC_IDX_REQE: next_rdata = {6'h00, request_enable_control};
            `VRPC_IDX_STAT: next_rdata = {6'h00, pll_stable, pll_enable};
            default: next_rdata = 8'h00;
        endcase
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? next_rdata : 8'h00;
        end
    end

endmodule // vrpc_voice_ctrl

// >>> sim/vrpc_voice_ctrl_checker.sv
// Port checker for the voice record and play control block
`timescale 1ns/1ps
module vrpc_voice_ctrl_checker #(
    parameter CLK_HZ = 25000000,
    parameter ACC_W = 32
) (
    input wire clk_sys,
    input wire rst_n,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire power_down,
    input wire pll_lock,
    input wire pll_enable,
    input wire input_converter_enable,
    input wire input_converter_run,
    input wire output_converter_enable,
    input wire amplifier_enable,
    input wire speaker_unmute,
    input wire record_request,
    input wire play_request,
    input wire dac_strobe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ==========================================
    // Sequences
    sequence lock_gone;
        !pll_lock [*6];
    endsequence
    sequence pulse_gap(s);
        s ##1 !s [*8];
    endsequence
    // ==========================================
    // Assertions
    pd_pll_off_a: assert property (power_down |=> !pll_enable)
        else $error("pll runs in power-down");
    pd_outs_off_a: assert property (power_down |=> !(
        input_converter_enable || input_converter_run ||
        output_converter_enable || amplifier_enable))
        else $error("converter or amplifier on in power-down");
    mute_spk_off_a: assert property ($past(!speaker_unmute) &&
        !speaker_unmute |-> !output_converter_enable && !amplifier_enable)
        else $error("speaker path on while muted");
    run_needs_en_a: assert property (
        input_converter_run |-> input_converter_enable)
        else $error("converter runs while disabled");
    rec_pulse_a: assert property (
        record_request |-> pulse_gap(record_request))
        else $error("record request not a single pulse");
    play_pulse_a: assert property (
        play_request |-> pulse_gap(play_request))
        else $error("play request not a single pulse");
    dac_pulse_a: assert property (dac_strobe |-> pulse_gap(dac_strobe))
        else $error("converter strobe not a single pulse");
    lock_wait_a: assert property (lock_gone |-> !record_request &&
        !play_request && !dac_strobe)
        else $error("sample activity without pll lock");
    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read answer cycle");
endmodule // vrpc_voice_ctrl_checker

bind vrpc_voice_ctrl vrpc_voice_ctrl_checker #(.CLK_HZ(CLK_HZ),
    .ACC_W(ACC_W)) u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_down(power_down),
    .pll_lock(pll_lock), .pll_enable(pll_enable),
    .input_converter_enable(input_converter_enable),
    .input_converter_run(input_converter_run),
    .output_converter_enable(output_converter_enable),
    .amplifier_enable(amplifier_enable), .speaker_unmute(speaker_unmute),
    .record_request(record_request), .play_request(play_request),
    .dac_strobe(dac_strobe));

// >>> sim/vrpc_partner.sv
// Converter side model: pll lock timing and microphone samples
`timescale 1ns/1ps
module vrpc_partner (
    input wire clk_sys,
    input wire rst_n,
    input wire pll_enable,
    input wire record_request,
    input wire [15:0] adc_set,
    output reg pll_lock,
    output reg [15:0] adc_data
);
    reg [2:0] wait_cnt;
    // Lock comes late after enable, drops at once
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wait_cnt <= 3'h0;
            pll_lock <= 1'b0;
            adc_data <= 16'h0000;
        end else begin
            wait_cnt <= pll_enable ? wait_cnt + {2'h0, ~&wait_cnt} : 3'h0;
            pll_lock <= pll_enable && wait_cnt == 3'h7;
            if (record_request) begin
                adc_data <= adc_set;
            end
        end
    end
endmodule // vrpc_partner

// >>> sim/vrpc_voice_ctrl_tb.sv
// Self-checking bench for the voice record and play control block
`timescale 1ns/1ps
module vrpc_voice_ctrl_tb;
    localparam CLKHZ = 240000;
    localparam [19:0] SRC_A = 20'h88101;
    localparam [39:0] SRC_V = 40'h02_01_01_40_07;
    localparam [31:0] CMP = 32'haa_d5_80_ff;
    localparam [31:0] EXP_C = 32'h05_01_01_00;
    localparam [31:0] EXP_H = 32'haa_80_ff_a5;
    localparam [63:0] EXP_Q = 64'h7e00_7d7c_0000_a53c;
    reg rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, power_down = 1'b0;
    reg clk_sys;
    reg [3:0] reg_addr = 4'h0;
    reg [7:0] reg_wdata = 8'h00;
    reg [15:0] adc_set = 16'h0000;
    wire [7:0] reg_rdata;
    wire pll_lock, pll_enable, input_converter_enable, input_converter_run;
    wire output_converter_enable, amplifier_enable, microphone_unmute;
    wire speaker_unmute, record_request, play_request, dac_strobe;
    wire [6:0] speaker_volume;
    wire [15:0] adc_data, dac_data;
    reg [7:0] mdl [0:15];
    reg [7:0] d, l0;
    reg [15:0] q, x, g39;
    integer n_errors = 0, n_tests = 0, seed = 38665, k, n;
    vrpc_voice_ctrl #(.CLK_HZ(CLKHZ)) u_vrpc_voice_ctrl (
        .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .power_down(power_down),
        .pll_lock(pll_lock), .adc_data(adc_data), .pll_enable(pll_enable),
        .input_converter_enable(input_converter_enable),
        .input_converter_run(input_converter_run),
        .output_converter_enable(output_converter_enable),
        .amplifier_enable(amplifier_enable),
        .microphone_unmute(microphone_unmute),
        .speaker_unmute(speaker_unmute), .speaker_volume(speaker_volume),
        .record_request(record_request), .play_request(play_request),
        .dac_data(dac_data), .dac_strobe(dac_strobe));
    vrpc_partner u_vrpc_partner (.clk_sys(clk_sys), .rst_n(rst_n),
        .pll_enable(pll_enable), .record_request(record_request),
        .adc_set(adc_set), .pll_lock(pll_lock), .adc_data(adc_data));
    // ==========================================
    // Model and bus tasks
    function [7:0] msk(input [3:0] a);
        case (a)
            4'h1: msk = 8'hf7;
            4'h2: msk = 8'h0f;
            4'h8: msk = 8'h03;
            4'h0, 4'h3, 4'h6, 4'h7: msk = 8'hff;
            default: msk = 8'h00;
        endcase
    endfunction
    function integer per_of(input [1:0] c);
        per_of = CLKHZ / (c == 2'b00 ? 8000 : c == 2'b01 ? 16000 :
            c == 2'b10 ? 12000 : 24000);
    endfunction
    task chk(input [15:0] g, input [15:0] e);
        begin
            n_tests = n_tests + 1;
            if (g !== e) begin
                n_errors = n_errors + 1;
                $display("ERROR %0t got %h exp %h", $time, g, e);
            end
        end
    endtask
    task wr(input [3:0] a, input [7:0] v);
        begin
            @(posedge clk_sys);
            reg_addr <= a;
            reg_wdata <= v;
            reg_wr <= 1'b1;
            @(posedge clk_sys);
            reg_wr <= 1'b0;
            mdl[a] = v & msk(a);
        end
    endtask
    task rd(input [3:0] a, output [7:0] v);
        begin
            @(posedge clk_sys);
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge clk_sys);
            reg_rd <= 1'b0;
            @(negedge clk_sys);
            v = reg_rdata;
        end
    endtask
    // Cycles between two pulses; converter sample kept at the second
    task per(input [1:0] s, output integer p);
        integer i, c;
        begin
            c = 0;
            p = 0;
            for (i = 0; i < 400 && c < 2; i = i + 1) begin
                @(posedge clk_sys);
                #1;
                if (c == 1) p = p + 1;
                if ((s == 0 ? record_request : s == 1 ? play_request :
                    dac_strobe) === 1'b1) c = c + 1;
                q = dac_data;
            end
        end
    endtask
    task rec(output [15:0] v);
        reg [7:0] a, b;
        begin
            per(2'd0, n);
            rd(4'h5, a);
            rd(4'h4, b);
            v = {a, b};
        end
    endtask
    task summarize;
        begin
            if (n_errors == 0 && n_tests > 0) $display("bench passed");
            else $display("bench failed");
            $finish;
        end
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors = n_errors + 1;
        summarize;
    end
    // ==========================================
    // Scenarios
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (k = 4; k < 16; k = k + 1) begin
            if (k < 6 || k > 8) wr(k[3:0], 8'hff);
        end
        for (k = 0; k < 16; k = k + 1) begin
            rd(k[3:0], d);
            chk(d, 8'h00);
        end
        for (k = 0; k < 12; k = k + 1) begin
            n = k % 6 < 4 ? k % 6 : k % 6 + 2;
            d = 8'($random(seed));
            wr(n[3:0], d);
            rd(n[3:0], d);
            chk(d, mdl[n]);
        end
        for (k = 0; k < 4; k = k + 1) wr(k[3:0], 8'h00);
        wr(4'h3, 8'h80);
        for (k = 0; k < 5; k = k + 1) begin
            wr(SRC_A[k*4 +: 4], SRC_V[k*8 +: 8]);
            repeat (2) @(negedge clk_sys);
            chk(pll_enable, 1'b1);
            if (k == 0) chk({input_converter_enable, amplifier_enable,
                output_converter_enable}, 3'h7);
            @(posedge clk_sys);
            power_down <= 1'b1;
            repeat (2) @(negedge clk_sys);
            chk({pll_enable, input_converter_enable, amplifier_enable,
                output_converter_enable}, 4'h0);
            @(posedge clk_sys);
            power_down <= 1'b0;
            wr(SRC_A[k*4 +: 4], 8'h00);
            repeat (2) @(negedge clk_sys);
            chk(pll_enable, 1'b0);
        end
        wr(4'h1, 8'h03);
        wr(4'h3, 8'h00);
        repeat (2) @(negedge clk_sys);
        chk({speaker_unmute, amplifier_enable, output_converter_enable},
            3'h0);
        wr(4'h1, 8'h00);
        wr(4'h8, 8'h03);
        for (k = 0; k < 4; k = k + 1) begin
            wr(4'h1, {k[1:0], ~k[1:0], 4'h0});
            per(2'd0, n);
            per(2'd0, n);
            chk(n, per_of(k[1:0]));
            per(2'd1, n);
            per(2'd1, n);
            chk(n, per_of(~k[1:0]));
        end
        wr(4'h8, 8'h01);
        wr(4'h1, 8'h04);
        repeat (2500) @(posedge clk_sys);
        wr(4'h0, 8'hc0);
        x = 16'($random(seed));
        adc_set <= x;
        rec(q);
        chk(q, x);
        chk({microphone_unmute, input_converter_run}, 2'h3);
        wr(4'h0, 8'h40);
        rec(q);
        chk(q, 16'h0000);
        wr(4'h0, 8'h80);
        rec(q);
        chk(q, 16'h0000);
        adc_set <= 16'h0100;
        wr(4'h0, 8'he7);
        rec(q);
        chk(q > 16'd2411 && q < 16'd2421, 1'b1);
        g39 = q;
        wr(4'h0, 8'hff);
        rec(q);
        chk(q, g39);
        rd(4'h4, l0);
        for (k = 0; k < 4; k = k + 1) begin
            adc_set <= k[0] ? 16'h7fff : 16'h0000;
            wr(4'h2, k[1] ? 8'h0a : 8'h02);
            rec(q);
            chk(q, {CMP[k*8 +: 8], l0});
        end
        wr(4'h3, 8'h95);
        wr(4'h1, 8'h01);
        for (k = 0; k < 4; k = k + 1) begin
            wr(4'h2, EXP_C[k*8 +: 8]);
            wr(4'h7, EXP_H[k*8 +: 8]);
            wr(4'h6, 8'h3c);
            per(2'd2, n);
            chk(q, EXP_Q[k*16 +: 16]);
            chk({speaker_unmute, speaker_volume}, 8'h95);
        end
        summarize;
    end
endmodule // vrpc_voice_ctrl_tb
